// ### verilog/serial_port_status.sv
/*
 status, interrupt mask and character holding logic of a serial port,
 reached over an Avalon-MM slave with waitrequest.
 assumes the receiver, transmitter, timers and dma channels run on the
 same clock; their events come as one-cycle pulses, the dma flags as levels; modem lines are pins.

*/
`timescale 1ns/1ps
`include "serial_status_defs.svh"

module serial_port_status (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // register bus
   input wire logic [4:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // receiver side
   input wire logic rx_char_valid_in,
   input wire serial_status_pkg::serial_char_t rx_char_in,
   input wire serial_status_pkg::line_events_t line_events_in,
   input wire logic timeout_value_zero_in,
   // transmitter side
   input wire logic tx_take_in,
   input wire logic tx_shift_busy_in,
   input wire logic break_started_in,
   output logic tx_char_valid_out,
   output serial_status_pkg::serial_char_t tx_char_out,
   output logic rx_enable_out,
   output logic tx_enable_out,
   output logic begin_break_out,
   output logic arm_idle_timer_out,
   output logic clear_repeat_out,
   // dma channel signals
   input wire logic rx_dma_done_in,
   input wire logic tx_dma_done_in,
   input wire logic tx_dma_buffer_empty_in,
   input wire logic rx_dma_buffer_full_in,
   // modem control pins
   input wire serial_status_pkg::modem_lines_t modem_in,
   output logic irq_out
);

   logic served_q;
   logic rd_done, wr_done;
   logic [31:0] wmask;
   logic [31:0] rdata_d;
   logic [31:0] readdata_q;
   logic [1:0] control_q;
   logic wr_control, wr_enable, wr_disable, wr_tx, rd_status, rd_rx;
   logic cmd_clear_status, cmd_begin_break, cmd_arm_timer;
   logic cmd_clear_repeat, cmd_clear_not_ack;
   logic rx_ready_q, rx_pending_q;
   serial_status_pkg::serial_char_t rx_hold_q;
   serial_status_pkg::serial_char_t tx_hold_q;
   logic tx_full_q, break_pending_q;
   logic brk_q, ovr_q, frm_q, par_q, tmo_q, rep_q, not_acknowledged_flag_q;
   serial_status_pkg::modem_lines_t modem_s1_q, modem_s2_q, modem_s3_q;
   logic [3:0] change_q;
   logic [3:0] toggled;
   logic [19:0] mask_q;
   logic [23:0] status;
   logic tx_free, drained;
   logic [4:0] cmd_q;
   localparam logic [19:0] MASK_INIT = `MASK_RESET;
   localparam logic [19:0] MASK_VALID = `IRQ_VALID_BITS;

   // bus slave: every access is answered one enabled (ce_in high) cycle after it is presented
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~served_q;
   assign rd_done = avs_read_in & served_q & ce_in;
   assign wr_done = avs_write_in & served_q & ce_in;
   assign wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                   {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         served_q <= 1'b0;
      end else if (ce_in) begin
         served_q <= (avs_read_in | avs_write_in) & ~served_q;
      end
   end

   assign wr_control = wr_done && (avs_address_in == `OFS_CONTROL);
   assign wr_enable = wr_done && (avs_address_in == `OFS_IRQ_ENABLE);
   assign wr_disable = wr_done && (avs_address_in == `OFS_IRQ_DISABLE);
   assign wr_tx = wr_done && (avs_address_in == `OFS_TX_HOLDING) &&
                  (avs_byteenable_in[1:0] != 2'h0);
   assign rd_status = rd_done && (avs_address_in == `OFS_CHANNEL_STATUS);
   assign rd_rx = rd_done && (avs_address_in == `OFS_RX_HOLDING);

   // command bits act for the one write cycle only
   assign cmd_clear_status = wr_control && avs_byteenable_in[0] &&
                             avs_writedata_in[`CTL_CLEAR_STATUS];
   assign cmd_begin_break = wr_control && avs_byteenable_in[0] &&
                            avs_writedata_in[`CTL_BEGIN_BREAK];
   assign cmd_arm_timer = wr_control && avs_byteenable_in[0] &&
                          avs_writedata_in[`CTL_ARM_IDLE_TIMER];
   assign cmd_clear_repeat = wr_control && avs_byteenable_in[0] &&
                             avs_writedata_in[`CTL_CLEAR_REPEAT];
   assign cmd_clear_not_ack = wr_control && avs_byteenable_in[0] &&
                              avs_writedata_in[`CTL_CLEAR_NOT_ACK];

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         control_q <= `CONTROL_RESET;
      end else if (ce_in && wr_control && avs_byteenable_in[0]) begin
         control_q <= avs_writedata_in[`CTL_TX_ENABLE:`CTL_RX_ENABLE];
      end
   end
   assign rx_enable_out = control_q[`CTL_RX_ENABLE];
   assign tx_enable_out = control_q[`CTL_TX_ENABLE];

   // command strobes to the timers and transmitter, registered pulses
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cmd_q <= 5'h00;
      end else if (ce_in) begin
         cmd_q <= {cmd_arm_timer, cmd_clear_repeat, 3'h0};
      end
   end
   assign arm_idle_timer_out = cmd_q[4];
   assign clear_repeat_out = cmd_q[3];

   // interrupt mask: per-bit set/clear, bit positions shared with status
   genvar gi;
   generate
      for (gi = 0; gi < 20; gi++) begin : g_mask
         always_ff @(posedge ref_clk_in) begin
            if (rst_in) begin
               mask_q[gi] <= MASK_INIT[gi];
            end else if (ce_in) begin
               if (wr_enable && wmask[gi] && avs_writedata_in[gi]) begin
                  mask_q[gi] <= MASK_VALID[gi];
               end else if (wr_disable && wmask[gi] &&
                            avs_writedata_in[gi]) begin
                  mask_q[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // receive path
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rx_hold_q <= '0;
      end else if (ce_in && rx_char_valid_in) begin
         rx_hold_q <= rx_char_in;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rx_ready_q <= 1'b0;
         rx_pending_q <= 1'b0;
      end else if (ce_in) begin
         if (!rx_enable_out) begin
            rx_ready_q <= 1'b0;
            if (rx_char_valid_in) begin
               rx_pending_q <= 1'b1;
            end
         end else if (rx_char_valid_in || rx_pending_q) begin
            rx_ready_q <= 1'b1;
            rx_pending_q <= 1'b0;
         end else if (rd_rx) begin
            rx_ready_q <= 1'b0;
         end
      end
   end

   // transmit path
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         tx_hold_q <= '0;
         tx_full_q <= 1'b0;
      end else if (ce_in) begin
         if (wr_tx) begin
            tx_hold_q.is_command <= avs_writedata_in[`HOLD_CMD_BIT];
            tx_hold_q.character <= avs_writedata_in[8:0];
            tx_full_q <= 1'b1;
         end else if (tx_take_in) begin
            tx_full_q <= 1'b0;
         end
      end
   end
   assign tx_char_valid_out = tx_full_q & tx_enable_out & ~break_pending_q;
   assign tx_char_out = tx_hold_q;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         break_pending_q <= 1'b0;
      end else if (ce_in) begin
         if (cmd_begin_break) begin
            break_pending_q <= 1'b1;
         end else if (break_started_in) begin
            break_pending_q <= 1'b0;
         end
      end
   end
   assign begin_break_out = break_pending_q;

   assign tx_free = tx_enable_out & ~tx_full_q & ~break_pending_q;
   assign drained = tx_enable_out & ~tx_full_q & ~tx_shift_busy_in;

   // sticky line flags: a new event wins over its clear
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         brk_q <= 1'b0;
         ovr_q <= 1'b0;
         frm_q <= 1'b0;
         par_q <= 1'b0;
      end else if (ce_in) begin
         brk_q <= line_events_in.line_break |
                  (brk_q & ~cmd_clear_status);
         ovr_q <= line_events_in.overrun | (ovr_q & ~cmd_clear_status);
         frm_q <= line_events_in.framing | (frm_q & ~cmd_clear_status);
         par_q <= line_events_in.parity | (par_q & ~cmd_clear_status);
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         tmo_q <= 1'b0;
         rep_q <= 1'b0;
         not_acknowledged_flag_q <= 1'b0;
      end else if (ce_in) begin
         tmo_q <= line_events_in.timeout | (tmo_q & ~cmd_arm_timer);
         rep_q <= line_events_in.repeat_limit |
                  (rep_q & ~cmd_clear_repeat);
         not_acknowledged_flag_q <= line_events_in.not_ack |
                   (not_acknowledged_flag_q & ~cmd_clear_not_ack);
      end
   end

   // modem pins: two-stage synchroniser, third stage for toggle detection
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         modem_s1_q <= '0;
         modem_s2_q <= '0;
         modem_s3_q <= '0;
      end else if (ce_in) begin
         modem_s1_q <= modem_in;
         modem_s2_q <= modem_s1_q;
         modem_s3_q <= modem_s2_q;
      end
   end
   assign toggled = modem_s2_q ^ modem_s3_q;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         change_q <= 4'h0;
      end else if (ce_in) begin
         change_q <= toggled | (change_q & {4{~rd_status}});
      end
   end

   // channel status word; change/level nibbles are ordered ring..clear-send
   always_comb begin
      status = 24'h000000;
      status[`ST_RX_READY] = rx_ready_q;
      status[`ST_TX_FREE] = tx_free;
      status[`ST_BREAK] = brk_q;
      status[`ST_RX_DMA] = rx_dma_done_in;
      status[`ST_TX_DMA] = tx_dma_done_in;
      status[`ST_OVERRUN] = ovr_q;
      status[`ST_FRAMING] = frm_q;
      status[`ST_PARITY] = par_q;
      status[`ST_TIMEOUT] = tmo_q & ~timeout_value_zero_in;
      status[`ST_DRAINED] = drained;
      status[`ST_REPEAT] = rep_q;
      status[`ST_TXBUF_E] = tx_dma_buffer_empty_in;
      status[`ST_RXBUF_F] = rx_dma_buffer_full_in;
      status[`ST_NOT_ACKNOWLEDGED_FLAG] = not_acknowledged_flag_q;
      status[`ST_CHANGE_LO +: 4] = {change_q[0], change_q[1], change_q[2],
                                    change_q[3]};
      status[`ST_LEVEL_LO +: 4] = {modem_s2_q.clear_send, modem_s2_q.carrier,
                                   modem_s2_q.set_ready,
                                   modem_s2_q.ring};
   end

   assign irq_out = |(status[19:0] & mask_q);

   // read data: unmapped and write-only offsets read as zero
   always_comb begin
      rdata_d = 32'h00000000;
      case (avs_address_in)
         `OFS_CONTROL: rdata_d[1:0] = control_q;
         `OFS_IRQ_MASK: rdata_d[19:0] = mask_q;
         `OFS_CHANNEL_STATUS: rdata_d[23:0] = status;
         `OFS_RX_HOLDING: begin
            rdata_d[8:0] = rx_hold_q.character;
            rdata_d[`HOLD_CMD_BIT] = rx_hold_q.is_command;
         end
         default: rdata_d = 32'h00000000;
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         readdata_q <= 32'h00000000;
      end else if (ce_in && avs_read_in && !served_q) begin
         readdata_q <= rdata_d;
      end
   end
   assign avs_readdata_out = readdata_q;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_rx_read;
      ce_in && rd_rx && !rx_char_valid_in && !rx_pending_q;
   endsequence

   property p_rx_read_clears;
      s_rx_read |=> !rx_ready_q;
   endproperty
   a_rx_read_clears: assert property (p_rx_read_clears)
      else $error("receive ready survived a holding read");

   property p_rx_reenable;
      ce_in && rx_enable_out && rx_pending_q |=> rx_ready_q && !rx_pending_q;
   endproperty
   a_rx_reenable: assert property (p_rx_reenable)
      else $error("receive ready not raised after re-enable");

   property p_tx_free;
      (tx_full_q || break_pending_q || !tx_enable_out) |-> !status[1];
   endproperty
   a_tx_free: assert property (p_tx_free)
      else $error("transmit free while holding busy or disabled");

   sequence s_break_seen;
      ce_in && line_events_in.line_break;
   endsequence

   property p_break_sticky;
      s_break_seen ##1 (ce_in && !cmd_clear_status)[*2] |=> brk_q;
   endproperty
   a_break_sticky: assert property (p_break_sticky)
      else $error("break flag lost without clear status");

   property p_overrun_set;
      ce_in && line_events_in.overrun |=> ovr_q && status[5];
   endproperty
   a_overrun_set: assert property (p_overrun_set)
      else $error("overrun flag not set after event");

   property p_timeout_zero;
      timeout_value_zero_in |-> !status[8];
   endproperty
   a_timeout_zero: assert property (p_timeout_zero)
      else $error("time-out reads set while value is zero");

   property p_drained;
      status[9] |-> tx_enable_out && !tx_full_q && !tx_shift_busy_in;
   endproperty
   a_drained: assert property (p_drained)
      else $error("drained while holding or shifter busy");

   property p_modem_change;
      ce_in && $changed(modem_s2_q.ring) ##1 !rd_status |=> change_q[3];
   endproperty
   a_modem_change: assert property (p_modem_change)
      else $error("ring change flag not set after toggle");

   property p_mask_disable;
      wr_disable && wmask[0] && avs_writedata_in[0] |=> !mask_q[0];
   endproperty
   a_mask_disable: assert property (p_mask_disable)
      else $error("disable write left mask bit set");

   property p_irq;
      irq_out == |(status[19:0] & mask_q);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt output disagrees with flags and mask");

endmodule // serial_port_status

// ### verilog/serial_status_defs.svh
/*
 register offsets, field positions and reset values of the serial port
 status block; included by the design, defines only
*/
`ifndef SERIAL_STATUS_DEFS_SVH
`define SERIAL_STATUS_DEFS_SVH

// byte offsets on the register bus
`define OFS_CONTROL        5'h00
`define OFS_IRQ_ENABLE     5'h08
`define OFS_IRQ_DISABLE    5'h0c
`define OFS_IRQ_MASK       5'h10
`define OFS_CHANNEL_STATUS 5'h14
`define OFS_RX_HOLDING     5'h18
`define OFS_TX_HOLDING     5'h1c

// control register fields
`define CTL_RX_ENABLE      0
`define CTL_TX_ENABLE      1
`define CTL_CLEAR_STATUS   2
`define CTL_BEGIN_BREAK    3
`define CTL_ARM_IDLE_TIMER 4
`define CTL_CLEAR_REPEAT   5
`define CTL_CLEAR_NOT_ACK  6

// status, mask and enable/disable bit positions
`define ST_RX_READY   0
`define ST_TX_FREE    1
`define ST_BREAK      2
`define ST_RX_DMA     3
`define ST_TX_DMA     4
`define ST_OVERRUN    5
`define ST_FRAMING    6
`define ST_PARITY     7
`define ST_TIMEOUT    8
`define ST_DRAINED    9
`define ST_REPEAT     10
`define ST_TXBUF_E    11
`define ST_RXBUF_F    12
`define ST_NOT_ACKNOWLEDGED_FLAG       13
`define ST_CHANGE_LO  16
`define ST_LEVEL_LO   20

// holding register fields
`define HOLD_CMD_BIT  15

// implemented interrupt sources (bits 14 and 15 are reserved)
`define IRQ_VALID_BITS 20'hf3fff
`define MASK_RESET     20'h00000
`define CONTROL_RESET  2'h0

`endif

// ### verilog/serial_status_pkg.sv
/*
 types shared by the serial port status block and its users;
 assumes serial_status_defs.svh supplies the numeric constants
*/
package serial_status_pkg;

   typedef struct packed {
      logic is_command;
      logic [8:0] character;
   } serial_char_t;

   typedef struct packed {
      logic line_break;
      logic overrun;
      logic framing;
      logic parity;
      logic timeout;
      logic repeat_limit;
      logic not_ack;
   } line_events_t;

   typedef struct packed {
      logic ring;
      logic set_ready;
      logic carrier;
      logic clear_send;
   } modem_lines_t;

endpackage

// ### bench/serial_line_peer.sv
/*
 far side of the serial port status block: receiver events, transmit
 shifter and modem pins; assumes the block's clock and synchronous reset
*/
`timescale 1ns/1ps

module serial_line_peer (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [3:0] take_delay_in,
   input wire logic tx_char_valid_in,
   input wire serial_status_pkg::serial_char_t tx_char_in,
   input wire logic begin_break_in,
   output logic tx_take_out,
   output logic tx_shift_busy_out,
   output logic break_started_out,
   output logic rx_char_valid_out,
   output serial_status_pkg::serial_char_t rx_char_out,
   output serial_status_pkg::line_events_t events_out,
   output serial_status_pkg::modem_lines_t modem_out,
   output serial_status_pkg::serial_char_t last_tx_out
);
   logic [3:0] wait_q;
   logic [3:0] busy_q;

   assign tx_shift_busy_out = (busy_q != 4'h0);

   initial begin
      rx_char_valid_out = 1'b0;
      rx_char_out = '0;
      events_out = '0;
      modem_out = '0;
   end

   // shifter takes a held character or starts a break after a delay
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         wait_q <= 4'h0;
         busy_q <= 4'h0;
         tx_take_out <= 1'b0;
         break_started_out <= 1'b0;
         last_tx_out <= '0;
      end else begin
         tx_take_out <= 1'b0;
         break_started_out <= 1'b0;
         if (busy_q != 4'h0) begin
            busy_q <= busy_q - 4'h1;
         end
         if ((tx_char_valid_in || begin_break_in) && !tx_take_out &&
             !break_started_out && busy_q == 4'h0) begin
            wait_q <= wait_q + 4'h1;
            if (wait_q == take_delay_in) begin
               wait_q <= 4'h0;
               break_started_out <= begin_break_in;
               tx_take_out <= !begin_break_in;
               busy_q <= begin_break_in ? 4'h0 : 4'hc;
               last_tx_out <= tx_char_in;
            end
         end
      end
   end

   task automatic send_char(input serial_status_pkg::serial_char_t c);
      @(posedge ref_clk_in);
      rx_char_valid_out <= 1'b1;
      rx_char_out <= c;
      @(posedge ref_clk_in);
      rx_char_valid_out <= 1'b0;
      // stale character never repeats on the bus
      rx_char_out <= ~c;
   endtask

   task automatic pulse_events(input serial_status_pkg::line_events_t e);
      @(posedge ref_clk_in);
      events_out <= e;
      @(posedge ref_clk_in);
      events_out <= '0;
   endtask

   task automatic set_modem(input serial_status_pkg::modem_lines_t m);
      @(posedge ref_clk_in);
      modem_out <= m;
   endtask
endmodule // serial_line_peer

// ### bench/serial_port_status_and_holding_tb.sv
/*
 self-checking bench of the serial port status block with a line peer;
 assumes the design package and defines header are compiled first
*/
`timescale 1ns/1ps

module serial_port_status_and_holding_tb;
   typedef struct packed {
      logic wr;
      logic [4:0] addr;
      logic [31:0] data;
   } row_t;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [4:0] address = 5'h00;
   logic rd = 1'b0, wr = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, got;
   logic waitreq, take, busy, brk_started, rx_valid, tx_valid, brk, irq;
   logic [3:0] delay = 4'h6, be = 4'hf;
   logic ce = 1'b1, rx_en, tx_en, arm, clr_rep;
   logic tmo_zero = 1'b0, rx_done = 1'b0, tx_done = 1'b0;
   logic tx_empty = 1'b0, rx_full = 1'b0;
   serial_status_pkg::serial_char_t rx_chr, tx_chr, last_tx;
   serial_status_pkg::line_events_t events;
   serial_status_pkg::modem_lines_t modem;
   int error_cnt = 0;
   int total_checks = 0;
   row_t rows [18] = '{
      '{1'b1, 5'h08, 32'h000fffff}, '{1'b0, 5'h10, 32'h000f3fff},
      '{1'b1, 5'h0c, 32'h00000000}, '{1'b0, 5'h10, 32'h000f3fff},
      '{1'b1, 5'h0c, 32'h00010001}, '{1'b0, 5'h10, 32'h000e3ffe},
      '{1'b1, 5'h0c, 32'hffffffff}, '{1'b0, 5'h10, 32'h00000000},
      '{1'b0, 5'h04, 32'h00000000}, '{1'b0, 5'h14, 32'h000027e6},
      '{1'b1, 5'h00, 32'h00000007}, '{1'b0, 5'h14, 32'h00002702},
      '{1'b1, 5'h00, 32'h00000013}, '{1'b0, 5'h14, 32'h00002602},
      '{1'b1, 5'h00, 32'h00000023}, '{1'b0, 5'h14, 32'h00002202},
      '{1'b1, 5'h00, 32'h00000043}, '{1'b0, 5'h14, 32'h00000202}};

   always #20 ref_clk_in = ~ref_clk_in;

   serial_port_status dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .ce_in(ce), .avs_address_in(address), .avs_read_in(rd),
      .avs_write_in(wr), .avs_byteenable_in(be),
      .avs_writedata_in(wdata), .avs_readdata_out(rdata),
      .avs_waitrequest_out(waitreq), .rx_char_valid_in(rx_valid),
      .rx_char_in(rx_chr), .line_events_in(events),
      .timeout_value_zero_in(tmo_zero), .tx_take_in(take),
      .tx_shift_busy_in(busy), .break_started_in(brk_started),
      .tx_char_valid_out(tx_valid), .tx_char_out(tx_chr),
      .rx_enable_out(rx_en), .tx_enable_out(tx_en), .begin_break_out(brk),
      .arm_idle_timer_out(arm), .clear_repeat_out(clr_rep),
      .rx_dma_done_in(rx_done), .tx_dma_done_in(tx_done),
      .tx_dma_buffer_empty_in(tx_empty), .rx_dma_buffer_full_in(rx_full),
      .modem_in(modem), .irq_out(irq));

   serial_line_peer peer (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .take_delay_in(delay), .tx_char_valid_in(tx_valid),
      .tx_char_in(tx_chr), .begin_break_in(brk), .tx_take_out(take),
      .tx_shift_busy_out(busy), .break_started_out(brk_started),
      .rx_char_valid_out(rx_valid), .rx_char_out(rx_chr),
      .events_out(events), .modem_out(modem), .last_tx_out(last_tx));

   task automatic chk_reg(input string what, input logic [31:0] exp,
                          input logic [31:0] seen);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic chk_pin(input string what, input logic exp,
                          input logic seen);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %b seen %b", what, exp, seen);
      end
   endtask

   // request held until the edge that sees waitrequest low
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      logic ws;
      int n = 0;
      @(posedge ref_clk_in);
      rd <= ~w;
      wr <= w;
      address <= a;
      wdata <= d;
      do begin
         @(posedge ref_clk_in);
         ws = waitreq;
         q = rdata;
         n++;
      end while (ws !== 1'b0 && n < 20);
      chk_pin("waitrequest", 1'b0, ws);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d, got);
   endtask

   task automatic rd_chk(input string what, input logic [4:0] a,
                         input logic [31:0] exp);
      bus(1'b0, a, 32'h0, got);
      chk_reg(what, exp, got);
   endtask

   task automatic run_row(input row_t r);
      if (r.wr) begin
         wr_reg(r.addr, r.data);
      end else begin
         rd_chk("row", r.addr, r.data);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (4000) @(posedge ref_clk_in);
      error_cnt++;
      $display("[ERR] watchdog expected done seen hang");
      end_sim();
   end

   initial begin
      repeat (3) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      wr_reg(5'h00, 32'h3);
      peer.pulse_events(7'h7f);
      for (int i = 0; i < 9; i++) run_row(rows[i]);
      for (int i = 9; i < 12; i++) run_row(rows[i]);
      for (int i = 12; i < 18; i++) run_row(rows[i]);
      wr_reg(5'h00, 32'h33);
      @(negedge ref_clk_in);
      chk_pin("arm out", 1'b1, arm);
      chk_pin("clr rep out", 1'b1, clr_rep);
      chk_pin("rx en out", 1'b1, rx_en);
      chk_pin("tx en out", 1'b1, tx_en);
      @(negedge ref_clk_in);
      chk_pin("arm out", 1'b0, arm);
      chk_pin("clr rep out", 1'b0, clr_rep);
      $display("test table done");
      peer.send_char(10'h3a5);
      rd_chk("status", 5'h14, 32'h203);
      rd_chk("rx hold", 5'h18, 32'h81a5);
      rd_chk("status", 5'h14, 32'h202);
      peer.send_char(10'h05a);
      rd_chk("rx hold", 5'h18, 32'h5a);
      peer.send_char(10'h011);
      wr_reg(5'h00, 32'h2);
      peer.send_char(10'h022);
      rd_chk("status", 5'h14, 32'h202);
      wr_reg(5'h00, 32'h3);
      rd_chk("status", 5'h14, 32'h203);
      wr_reg(5'h08, 32'h1);
      @(negedge ref_clk_in);
      chk_pin("irq", 1'b1, irq);
      bus(1'b0, 5'h18, 32'h0, got);
      @(negedge ref_clk_in);
      chk_pin("irq", 1'b0, irq);
      wr_reg(5'h0c, 32'h1);
      $display("test receive done");
      wr_reg(5'h1c, 32'h80ab);
      @(negedge ref_clk_in);
      chk_pin("tx valid", 1'b1, tx_valid);
      chk_reg("tx char", 32'h2ab, {22'h0, tx_chr});
      rd_chk("status", 5'h14, 32'h0);
      for (int n = 0; n < 30 && tx_valid !== 1'b0; n++) @(posedge ref_clk_in);
      rd_chk("status", 5'h14, 32'h2);
      for (int n = 0; n < 30 && busy !== 1'b0; n++) @(posedge ref_clk_in);
      rd_chk("status", 5'h14, 32'h202);
      chk_reg("line char", 32'h2ab, {22'h0, last_tx});
      wr_reg(5'h00, 32'h1);
      rd_chk("status", 5'h14, 32'h0);
      wr_reg(5'h00, 32'h3);
      rd_chk("status", 5'h14, 32'h202);
      delay <= 4'h2;
      wr_reg(5'h00, 32'hb);
      rd_chk("status", 5'h14, 32'h200);
      for (int n = 0; n < 30 && brk !== 1'b0; n++) @(posedge ref_clk_in);
      rd_chk("status", 5'h14, 32'h202);
      $display("test transmit done");
      {rx_done, tx_done, tx_empty, rx_full} <= 4'hf;
      rd_chk("status", 5'h14, 32'h1a1a);
      wr_reg(5'h08, 32'h8);
      @(negedge ref_clk_in);
      chk_pin("irq", 1'b1, irq);
      @(posedge ref_clk_in);
      rx_done <= 1'b0;
      @(negedge ref_clk_in);
      chk_pin("irq", 1'b0, irq);
      @(posedge ref_clk_in);
      {tx_done, tx_empty, rx_full} <= 3'h0;
      wr_reg(5'h0c, 32'h8);
      tmo_zero <= 1'b1;
      peer.pulse_events(7'h04);
      rd_chk("status", 5'h14, 32'h202);
      $display("test dma done");
      peer.set_modem(4'h8);
      repeat (4) @(posedge ref_clk_in);
      rd_chk("status", 5'h14, 32'h110202);
      rd_chk("status", 5'h14, 32'h100202);
      peer.set_modem(4'hf);
      repeat (4) @(posedge ref_clk_in);
      rd_chk("status", 5'h14, 32'hfe0202);
      rd_chk("status", 5'h14, 32'hf00202);
      $display("test modem done");
      ce <= 1'b0;
      peer.pulse_events(7'h20);
      ce <= 1'b1;
      rd_chk("ce low", 5'h14, 32'hf00202);
      be <= 4'h1;
      wr_reg(5'h08, 32'hffffffff);
      rd_chk("lane", 5'h10, 32'hff);
      be <= 4'hf;
      wr_reg(5'h0c, 32'hffffffff);
      rd_chk("mask", 5'h10, 32'h0);
      $display("test lanes done");
      peer.set_modem(4'h0);
      repeat (4) @(posedge ref_clk_in);
      rst_in <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      rd_chk("mask", 5'h10, 32'h0);
      rd_chk("status", 5'h14, 32'h0);
      $display("test reset done");
      end_sim();
   end
endmodule // serial_port_status_and_holding_tb
